// *** common/core_regs_pkg.sv ***
// constants shared by the core register file block
// assumes a single aclk domain and an axi4-lite master outside
package core_regs_pkg;
  localparam int          NUM_REGS    = 32;
  localparam logic [4:0]  PTR_X_LO    = 5'h1A;
  localparam logic [4:0]  PTR_Y_LO    = 5'h1C;
  localparam logic [4:0]  PTR_Z_LO    = 5'h1E;
  localparam logic [15:0] IO_BASE     = 16'h0020;
  localparam logic [15:0] IO_LAST     = 16'h005F;
  localparam logic [15:0] REG_LAST    = 16'h001F;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam int          BIT_IRQ_EN  = 7;
  localparam int          BIT_COPY    = 6;
  localparam int          BIT_HALF    = 5;
  localparam int          BIT_SIGN    = 4;
  localparam int          BIT_OVF     = 3;
  localparam int          BIT_NEG     = 2;
  localparam int          BIT_ZERO    = 1;
  localparam int          BIT_CARRY   = 0;
  // axi register map
  localparam logic [7:0]  OFS_FLAGS   = 8'h00;
  localparam logic [7:0]  OFS_PC      = 8'h04;
  localparam logic [7:0]  OFS_GPR     = 8'h80;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  typedef enum logic [1:0] {PM_DISP, PM_POSTINC, PM_PREDEC} ptr_mode_e;
endpackage

// *** core/core_regs.sv ***
// cpu working registers, pointer unit, flag register and fetch stage
// assumes decoder/alu on aclk drive the request ports; axi4-lite master
module core_regs
  import core_regs_pkg::*;
#(
  parameter int NUM_IRQ = 8
)(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  input  wire logic [15:0]        prog_data,
  input  wire logic               prog_two_word,
  output logic      [15:0]        program_counter,
  output logic      [15:0]        instr_q,
  output logic      [15:0]        instr_ext_q,
  input  wire logic [4:0]         rd_a_addr,
  input  wire logic [4:0]         rd_b_addr,
  output logic      [7:0]         rd_a_data,
  output logic      [7:0]         rd_b_data,
  output logic      [15:0]        rd_wide_data,
  input  wire logic               wr_en,
  input  wire logic               wr_wide,
  input  wire logic [4:0]         wr_addr,
  input  wire logic [15:0]        wr_data,
  input  wire logic               ptr_req,
  input  wire logic [1:0]         ptr_sel,
  input  wire logic [1:0]         ptr_mode,
  input  wire logic [5:0]         ptr_disp,
  input  wire logic               ptr_we,
  input  wire logic [7:0]         ptr_wdata,
  output logic      [15:0]        ptr_addr,
  output logic                    ptr_hit_reg,
  output logic                    ptr_hit_io,
  output logic      [5:0]         ptr_io_addr,
  output logic      [7:0]         ptr_reg_rdata,
  input  wire logic               table_req,
  output logic      [15:0]        flash_addr,
  input  wire logic [7:0]         alu_flag_we,
  input  wire logic [7:0]         alu_flags,
  input  wire logic               set_irq_enable_instr,
  input  wire logic               clear_irq_enable_instr,
  input  wire logic               return_from_irq_instr,
  input  wire logic               store_bit_to_copy_flag,
  input  wire logic               load_bit_from_copy_flag,
  input  wire logic [4:0]         bit_reg,
  input  wire logic [2:0]         bit_pos,
  input  wire logic [NUM_IRQ-1:0] irq_pending,
  input  wire logic               call_instr,
  output logic      [7:0]         status_flags,
  output logic                    irq_take_q,
  output logic      [$clog2(NUM_IRQ)-1:0] irq_index_q,
  output logic                    stack_push_q,
  output logic      [15:0]        stack_pc_q,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic      [1:0]         s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  localparam int IW = $clog2(NUM_IRQ);

  logic [7:0]  rf_q [NUM_REGS];
  logic [15:0] ptr_val;
  logic [15:0] ptr_next;
  logic [15:0] ptr_eff;
  logic [4:0]  ptr_lo;
  logic        irq_win;
  logic [IW-1:0] irq_sel;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic        aw_has_q;
  logic        w_has_q;
  logic        w_strb_q;
  logic        axi_wr;
  logic        axi_gpr_w;

  // pointer select, even register low byte
  always_comb
  begin
    unique case (ptr_sel)
      2'd0:    ptr_lo = PTR_X_LO;
      2'd1:    ptr_lo = PTR_Y_LO;
      default: ptr_lo = PTR_Z_LO;
    endcase
  end
  assign ptr_val = {rf_q[ptr_lo | 5'd1], rf_q[ptr_lo]};

  // effective address and written-back pointer
  always_comb
  begin
    ptr_eff  = ptr_val;
    ptr_next = ptr_val;
    unique case (ptr_mode_e'(ptr_mode))
      PM_DISP:    ptr_eff = ptr_val + {10'h000, ptr_disp};
      PM_POSTINC: ptr_next = ptr_val + 16'h0001;
      PM_PREDEC:
      begin
        ptr_next = ptr_val - 16'h0001;
        ptr_eff  = ptr_next;
      end
      default:    ptr_eff = ptr_val;
    endcase
  end

  function automatic logic is_reg(input logic [15:0] a);
    return a <= REG_LAST;
  endfunction

  // axi write completes when both halves held
  assign axi_wr    = aw_has_q && w_has_q && !s_axi_bvalid;
  assign axi_gpr_w = axi_wr && aw_q[7] && w_strb_q; // strobe kept with data

  // working registers, later writes take precedence
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        rf_q[i] <= 8'h00;
    end
    else if (clk_en)
    begin
      if (axi_gpr_w)
        rf_q[aw_q[6:2]] <= w_q[7:0];
      if (wr_en && !wr_wide)
        rf_q[wr_addr] <= wr_data[7:0];
      if (wr_en && wr_wide)
      begin
        rf_q[wr_addr & 5'h1E] <= wr_data[7:0];
        rf_q[wr_addr | 5'h01] <= wr_data[15:8];
      end
      if (ptr_req && ptr_mode_e'(ptr_mode) != PM_DISP)
      begin
        rf_q[ptr_lo]         <= ptr_next[7:0];
        rf_q[ptr_lo | 5'd1]  <= ptr_next[15:8];
      end
      if (ptr_req && ptr_we && is_reg(ptr_eff))
        rf_q[ptr_eff[4:0]] <= ptr_wdata;
      if (load_bit_from_copy_flag)
        rf_q[bit_reg][bit_pos] <= status_flags[BIT_COPY];
    end
  end

  // registered operand ports
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_a_data    <= 8'h00;
      rd_b_data    <= 8'h00;
      rd_wide_data <= 16'h0000;
    end
    else if (clk_en)
    begin
      rd_a_data    <= rf_q[rd_a_addr];
      rd_b_data    <= rf_q[rd_b_addr];
      rd_wide_data <= {rf_q[rd_a_addr | 5'h01], rf_q[rd_a_addr & 5'h1E]};
    end
  end

  // data-space decode of pointer accesses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr_addr      <= 16'h0000;
      ptr_hit_reg   <= 1'b0;
      ptr_hit_io    <= 1'b0;
      ptr_io_addr   <= 6'h00;
      ptr_reg_rdata <= 8'h00;
      flash_addr    <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (ptr_req)
      begin
        ptr_addr      <= ptr_eff;
        ptr_hit_reg   <= is_reg(ptr_eff);
        ptr_hit_io    <= ptr_eff >= IO_BASE && ptr_eff <= IO_LAST;
        ptr_io_addr   <= 6'(ptr_eff - IO_BASE);
        ptr_reg_rdata <= rf_q[ptr_eff[4:0]];
      end
      else
      begin
        ptr_hit_reg <= 1'b0;
        ptr_hit_io  <= 1'b0;
      end
      if (table_req)
        flash_addr <= {rf_q[PTR_Z_LO | 5'd1], rf_q[PTR_Z_LO]};
    end
  end

  // priority pick: lowest pending index
  always_comb
  begin
    irq_sel = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
      if (irq_pending[i])
        irq_sel = IW'(i);
  end
  assign irq_win = status_flags[BIT_IRQ_EN] && |irq_pending
                   && !clear_irq_enable_instr && !irq_take_q;

  // flag register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_flags <= FLAGS_RESET;
    else if (clk_en)
    begin
      if (axi_wr && aw_q == OFS_FLAGS && w_strb_q)
        status_flags <= {w_q[7:5], w_q[BIT_NEG] ^ w_q[BIT_OVF],
                         w_q[3:0]}; // software restore
      else
      begin
        // sign is never taken from the mask, only rebuilt from n and v
        for (int b = 0; b < 7; b++)
          if (alu_flag_we[b] && b != BIT_SIGN)
            status_flags[b] <= alu_flags[b];
        if (alu_flag_we[BIT_NEG] || alu_flag_we[BIT_OVF])
          status_flags[BIT_SIGN] <=
            (alu_flag_we[BIT_NEG] ? alu_flags[BIT_NEG]
                                  : status_flags[BIT_NEG]) ^
            (alu_flag_we[BIT_OVF] ? alu_flags[BIT_OVF]
                                  : status_flags[BIT_OVF]);
        if (store_bit_to_copy_flag)
          status_flags[BIT_COPY] <= rf_q[bit_reg][bit_pos];
        if (irq_win)
          status_flags[BIT_IRQ_EN] <= 1'b0;
        else if (clear_irq_enable_instr)
          status_flags[BIT_IRQ_EN] <= 1'b0;
        else if (set_irq_enable_instr || return_from_irq_instr)
          status_flags[BIT_IRQ_EN] <= 1'b1;
      end
    end
  end

  // interrupt take and return-address push
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_take_q   <= 1'b0;
      irq_index_q  <= '0;
      stack_push_q <= 1'b0;
      stack_pc_q   <= PC_RESET;
    end
    else if (clk_en)
    begin
      irq_take_q   <= irq_win;
      stack_push_q <= irq_win || call_instr;
      if (irq_win)
        irq_index_q <= irq_sel;
      if (irq_win || call_instr)
        stack_pc_q <= program_counter;
    end
  end

  // one-stage prefetch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      program_counter <= PC_RESET;
      instr_q         <= 16'h0000;
      instr_ext_q     <= 16'h0000;
    end
    else if (clk_en)
    begin
      program_counter <= program_counter + 16'h0001;
      if (prog_two_word)
        instr_ext_q <= prog_data;
      else
        instr_q <= prog_data;
    end
  end

  // axi write channels, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_has_q     <= 1'b0;
      w_has_q      <= 1'b0;
      aw_q         <= 8'h00;
      w_q          <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      w_strb_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q          <= s_axi_awaddr;
        aw_has_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q          <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb[0];
        w_has_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (axi_wr)
      begin
        aw_has_q     <= 1'b0;
        w_has_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q == OFS_FLAGS || aw_q[7]) ? RESP_OKAY
                                                      : RESP_SLVERR;
      end
      else if (s_axi_bready && s_axi_bvalid)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1; // both halves free again
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read channel, one cycle latency
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr[7])
          s_axi_rdata <= {24'h000000, rf_q[s_axi_araddr[6:2]]};
        else if (s_axi_araddr == OFS_FLAGS)
          s_axi_rdata <= {24'h000000, status_flags};
        else if (s_axi_araddr == OFS_PC)
          s_axi_rdata <= {16'h0000, program_counter};
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      else if (s_axi_rready && s_axi_rvalid)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1; // next read may be taken
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_step;
    clk_en;
  endsequence

  chk_sign_xor: assert property (
    s_step |=> status_flags[BIT_SIGN] == (status_flags[BIT_NEG]
      ^ status_flags[BIT_OVF]))
    else $error("sign flag not n xor v");
  chk_irq_gated: assert property (
    irq_take_q |-> $past(status_flags[BIT_IRQ_EN]))
    else $error("interrupt taken while disabled");
  chk_irq_clears: assert property (
    clk_en && irq_win && !axi_wr |=> !status_flags[BIT_IRQ_EN])
    else $error("enable not cleared on take");
  chk_return_from_irq_instr_sets: assert property (
    clk_en && return_from_irq_instr && !irq_win && !axi_wr
      && !clear_irq_enable_instr |=> status_flags[BIT_IRQ_EN])
    else $error("return did not set enable");
  chk_wr_read: assert property (
    clk_en && wr_en && !wr_wide && !ptr_req && !load_bit_from_copy_flag
      && !axi_wr ##1 clk_en && rd_a_addr == $past(wr_addr)
      |=> rd_a_data == $past(wr_data[7:0], 2))
    else $error("written register not read back");
  chk_postinc: assert property (
    clk_en && ptr_req && ptr_mode == 2'd1 && !wr_en && !axi_wr
      && !ptr_we && !load_bit_from_copy_flag
      |=> ptr_val == $past(ptr_val) + 16'h0001 || $past(ptr_sel) != ptr_sel)
    else $error("pointer not incremented");
  chk_io_window: assert property (
    ptr_hit_io |-> ptr_addr >= 16'h0020 && ptr_addr <= 16'h005F
      && ptr_io_addr == 6'(ptr_addr - 16'h0020))
    else $error("io decode wrong");
  chk_reg_window: assert property (
    ptr_hit_reg |-> ptr_addr < 16'h0020 && !ptr_hit_io)
    else $error("register decode wrong");
  chk_push_pc: assert property (
    clk_en && call_instr |=> stack_push_q
      && stack_pc_q == $past(program_counter))
    else $error("return address not pushed");
  chk_pc_step: assert property (
    clk_en |=> program_counter == $past(program_counter) + 16'h0001)
    else $error("fetch did not advance");
endmodule

// *** verification/alu_partner.sv ***
// alu partner: adds two register operands, drives sum and flag mask
// assumes operands come straight from the registered read ports
module alu_partner (
  input  wire logic       op_en,
  input  wire logic [7:0] opnd_a,
  input  wire logic [7:0] opnd_b,
  output logic      [7:0] sum,
  output logic      [7:0] flag_we,
  output logic      [7:0] flags
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] full;

  // add with flag generation, mask only while an op is issued
  always_comb
  begin
    full     = {1'b0, opnd_a} + {1'b0, opnd_b};
    sum      = full[7:0];
    flag_we  = op_en ? 8'h3F : 8'h00;
    flags    = 8'h00;
    flags[5] = (opnd_a[3:0] + opnd_b[3:0]) > 5'h0F;
    flags[3] = (opnd_a[7] == opnd_b[7]) && (sum[7] != opnd_a[7]);
    flags[2] = sum[7];
    flags[4] = flags[2] ^ flags[3];
    flags[1] = (sum == 8'h00);
    flags[0] = full[8];
  end
endmodule

// *** verification/core_regs_test.sv ***
// self-checking bench for core_regs against an integer model
// assumes alu_partner on the operand ports and an axi4-lite master here
module core_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import core_regs_pkg::*;

  logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic        prog_two_word = 1'b0, wr_en = 1'b0, wr_wide = 1'b0;
  logic        ptr_we = 1'b0, op_en = 1'b0;
  logic [15:0] prog_data = 16'h0000, wr_data = 16'h0000;
  logic [4:0]  rd_a_addr = 5'h00, rd_b_addr = 5'h00, wr_addr = 5'h00;
  logic [4:0]  bit_reg = 5'h00;
  logic [2:0]  bit_pos = 3'h0;
  logic [1:0]  ptr_sel = 2'h0, ptr_mode = 2'h0;
  logic [5:0]  ptr_disp = 6'h00;
  logic [7:0]  ptr_wdata = 8'h00, irq_pending = 8'h00, ctl = 8'h00;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        set_irq_enable_instr, clear_irq_enable_instr;
  logic        return_from_irq_instr, store_bit_to_copy_flag;
  logic        load_bit_from_copy_flag, call_instr, table_req, ptr_req;
  logic [15:0] program_counter, instr_q, instr_ext_q, rd_wide_data;
  logic [15:0] ptr_addr, flash_addr, stack_pc_q;
  logic [7:0]  rd_a_data, rd_b_data, ptr_reg_rdata, status_flags;
  logic [7:0]  alu_flag_we, alu_flags, alu_sum;
  logic [5:0]  ptr_io_addr;
  logic [2:0]  irq_index_q;
  logic        ptr_hit_reg, ptr_hit_io, irq_take_q, stack_push_q;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  int          gpr [32];
  int          fm, err_total, comparisons, takes, n, i, v, pc0;

  // one-hot strobes for the single-cycle instruction pulses
  assign {ptr_req, call_instr, table_req, load_bit_from_copy_flag,
          store_bit_to_copy_flag, return_from_irq_instr,
          clear_irq_enable_instr, set_irq_enable_instr} = ctl;

  core_regs #(.NUM_IRQ(8)) i_core_regs (.*);

  alu_partner i_alu_partner (
    .op_en   (op_en),
    .opnd_a  (rd_a_data),
    .opnd_b  (rd_b_data),
    .sum     (alu_sum),
    .flag_we (alu_flag_we),
    .flags   (alu_flags)
  );

  // clock and interrupt take counter
  initial
    forever #2.5 aclk = ~aclk;
  initial
    takes = 0;
  always @(posedge aclk)
    if (irq_take_q === 1'b1)
      takes <= takes + 1;

  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic expire;
    err_total++;
    wrap_up();
  endtask

  task automatic pulse(input logic [7:0] s);
    @(posedge aclk);
    ctl <= s;
    @(posedge aclk);
    ctl <= 8'h00;
    #1;
  endtask

  task automatic wr_reg(input int a, input int d, input bit w);
    @(posedge aclk);
    wr_en <= 1'b1;
    wr_wide <= w;
    wr_addr <= 5'(a);
    wr_data <= 16'(d);
    @(posedge aclk);
    wr_en <= 1'b0;
    gpr[a] = d & 255;
    if (w)
      gpr[a | 1] = (d >> 8) & 255;
  endtask

  task automatic rd_chk(input int a, input int b);
    @(posedge aclk);
    rd_a_addr <= 5'(a);
    rd_b_addr <= 5'(b);
    @(posedge aclk);
    #1;
    chk("rd_a", rd_a_data, gpr[a]);
    chk("rd_b", rd_b_data, gpr[b]);
    chk("rd_wide", rd_wide_data, gpr[a & 30] + 256 * gpr[a | 1]);
  endtask

  task automatic ptr_op(input int sel, input int mode, input int disp);
    int lo, base, ad;
    lo = 26 + 2 * (sel > 2 ? 2 : sel);
    base = gpr[lo] + 256 * gpr[lo + 1];
    ad = mode == 0 ? base + disp : mode == 1 ? base : base - 1;
    base = mode == 1 ? base + 1 : mode == 2 ? base - 1 : base;
    @(posedge aclk);
    ptr_sel <= 2'(sel);
    ptr_mode <= 2'(mode);
    ptr_disp <= 6'(disp);
    pulse(8'h80);
    gpr[lo] = base & 255;
    gpr[lo + 1] = (base >> 8) & 255;
    chk("ptr_addr", ptr_addr, ad);
    chk("hit_reg", ptr_hit_reg, ad < 32);
    chk("hit_io", ptr_hit_io, ad >= 32 && ad < 96);
    if (ad < 32)
      chk("ptr_rd", ptr_reg_rdata, gpr[ad]);
    if (ad >= 32 && ad < 96)
      chk("io_addr", ptr_io_addr, ad - 32);
  endtask

  task automatic bitop(input logic [7:0] s, input int r, input int p);
    @(posedge aclk);
    bit_reg <= 5'(r);
    bit_pos <= 3'(p);
    pulse(s);
  endtask

  // register 2 plus register 3 into register 4 through the partner
  task automatic alu_add(input int va, input int vb);
    int r, ov;
    wr_reg(2, va, 0);
    wr_reg(3, vb, 0);
    @(posedge aclk);
    rd_a_addr <= 5'h02;
    rd_b_addr <= 5'h03;
    @(posedge aclk);
    @(posedge aclk);
    op_en <= 1'b1;
    wr_en <= 1'b1;
    wr_wide <= 1'b0;
    wr_addr <= 5'h04;
    wr_data <= {8'h00, alu_sum};
    @(posedge aclk);
    op_en <= 1'b0;
    wr_en <= 1'b0;
    #1;
    r = (va + vb) & 255;
    gpr[4] = r;
    ov = ((va ^ r) & (vb & 128 ? ~r : r) & 128) != 0;
    ov = ((va & 128) == (vb & 128)) && ((r & 128) != (va & 128));
    fm = (fm & 192) | (((va & 15) + (vb & 15)) > 15) << 5 | ov << 3;
    fm = fm | ((r >> 7) ^ ov) << 4 | (r >> 7) << 2 | (r == 0) << 1;
    fm = fm | (va + vb > 255);
    chk("alu_flags", status_flags, fm);
    rd_chk(4, 4);
  endtask

  task automatic axi_wr(input logic [7:0] a, input int d,
                        output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    for (n = 0; n < 50 && !tb; n++)
    begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!tb)
      expire();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    for (n = 0; n < 50 && !tr; n++)
    begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!tr)
      expire();
  endtask

  // main sequence
  initial
  begin
    void'($urandom(18));
    fm = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("flags_rst", status_flags, FLAGS_RESET);
    pc0 = program_counter;
    v = $urandom & 16'hFFFF;
    @(posedge aclk);
    prog_data <= 16'(v);
    @(posedge aclk);
    #1;
    chk("fetch", instr_q, v);
    chk("pc_step", program_counter, (pc0 + 2) & 16'hFFFF);
    // second half of a two-word instruction lands in its own register
    @(posedge aclk);
    prog_two_word <= 1'b1;
    prog_data <= 16'(~v);
    @(posedge aclk);
    prog_two_word <= 1'b0;
    #1;
    chk("fetch_ext", instr_ext_q, (~v) & 16'hFFFF);
    chk("fetch_keep", instr_q, v);
    for (i = 0; i < 32; i++)
      wr_reg(i, $urandom & 255, 0);
    wr_reg(16, $urandom & 16'hFFFF, 1);
    for (i = 0; i < 32; i++)
      rd_chk(i, 31 - i);
    wr_reg(26, 16'h0011, 1);
    wr_reg(28, 16'h0003, 1);
    wr_reg(30, 16'h005F, 1);
    ptr_op(0, 2, 0);
    ptr_op(0, 1, 0);
    ptr_op(0, 0, 15);
    ptr_op(1, 0, 63);
    ptr_op(3, 1, 0);
    ptr_op(2, 0, 0);
    // data write through x into register 0x11
    v = $urandom & 255;
    @(posedge aclk);
    ptr_we <= 1'b1;
    ptr_wdata <= 8'(v);
    ptr_op(0, 0, 0);
    ptr_we <= 1'b0;
    gpr[17] = v;
    rd_chk(17, 17);
    pulse(8'h20);
    chk("flash", flash_addr, gpr[30] + 256 * gpr[31]);
    alu_add(128, 128);
    alu_add(15, 1);
    alu_add(127, 1);
    alu_add($urandom & 255, $urandom & 255);
    bitop(8'h08, 16, 3);
    fm = fm & ~64 | ((gpr[16] >> 3) & 1) << 6;
    chk("copy_st", status_flags, fm);
    bitop(8'h10, 5, 0);
    gpr[5] = gpr[5] & ~1 | (fm >> 6) & 1;
    rd_chk(5, 5);
    @(posedge aclk);
    irq_pending <= 8'h0C;
    repeat (3) @(posedge aclk);
    #1;
    chk("no_take", takes, 0);
    pulse(8'h01);
    for (i = 0; i < 8 && takes == 0; i++)
      @(posedge aclk);
    #1;
    if (takes == 0)
      expire();
    chk("irq_idx", irq_index_q, 2);
    chk("ie_clr", status_flags[7], 0);
    @(posedge aclk);
    irq_pending <= 8'h00;
    pulse(8'h04);
    chk("return_from_irq_instr", status_flags[7], 1);
    chk("one_take", takes, 1);
    pulse(8'h02);
    chk("cli", status_flags[7], 0);
    pulse(8'h01);
    chk("sei", status_flags[7], 1);
    pulse(8'h02);
    // freeze: nothing may move while clk_en is low
    @(posedge aclk);
    clk_en <= 1'b0;
    pc0 = program_counter;
    pulse(8'h01);
    chk("frz_pc", program_counter, (pc0 + 1) & 16'hFFFF);
    chk("frz_ie", status_flags[7], 0);
    @(posedge aclk);
    clk_en <= 1'b1;
    pc0 = program_counter;
    pulse(8'h40);
    chk("push", stack_push_q, 1);
    chk("push_pc", stack_pc_q, (pc0 + 1) & 16'hFFFF);
    axi_rd(OFS_FLAGS, rd, rr);
    chk("axi_flags", rd, fm);
    v = $urandom & 8'h6F;
    v = v | ((((v >> 2) ^ (v >> 3)) & 1) << 4);
    axi_wr(OFS_FLAGS, v, rr);
    #1;
    fm = v;
    chk("wr_resp", rr, RESP_OKAY);
    chk("flags_port", status_flags, fm);
    axi_wr(OFS_GPR + 8'h1C, 32'h000000A5, rr);
    gpr[7] = 165;
    rd_chk(7, 7);
    axi_rd(OFS_GPR + 8'h14, rd, rr);
    chk("axi_gpr", rd, gpr[5]);
    axi_rd(8'h08, rd, rr);
    chk("rresp", rr, RESP_SLVERR);
    chk("rdata_bad", rd, 0);
    axi_wr(8'h40, 0, rr);
    chk("bresp", rr, RESP_SLVERR);
    wrap_up();
  end
endmodule
